// >>> rtl/nvbc_defines.svh
// constants of the byte-wide nonvolatile store controller
`ifndef NVBC_DEFINES_SVH
`define NVBC_DEFINES_SVH
// io-space register selects
`define NVBC_SEL_INDEX   2'h0
`define NVBC_SEL_VALUE   2'h1
`define NVBC_SEL_CONTROL 2'h2
// control register field positions
`define NVBC_ACT_HI      5
`define NVBC_ACT_LO      4
`define NVBC_RDY_IE      3
`define NVBC_ARM         2
`define NVBC_TRIG        1
`define NVBC_RSTB        0
// action select encodings and reset value
`define NVBC_ACT_RESET   2'h0
`define NVBC_ACT_ERWR    2'h0
`define NVBC_ACT_ERASE   2'h1
`define NVBC_ACT_WRITE   2'h2
// timing and erased byte value
`define NVBC_ARM_CYCLES  3'h4
`define NVBC_PROG_STALL  3'h2
`define NVBC_READ_STALL  3'h4
`define NVBC_ERWR_US     3400
`define NVBC_SPLIT_US    1800
`define NVBC_OSC_KHZ     8000
`define NVBC_ERASED_BYTE 8'hFF
`endif

// >>> rtl/nvbc_pkg.sv
// types of the byte-wide nonvolatile store controller
package nvbc_pkg;
  typedef enum logic [1:0] {
    NVBC_IDLE = 2'b01,
    NVBC_PROG = 2'b10
  } nvbc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } nvbc_io_t;

  typedef struct packed {
    nvbc_state_t st;
    logic [6:0]  index;
    logic [7:0]  value;
    logic [1:0]  act;
    logic        rdy_ie;
    logic        arm;
    logic [2:0]  arm_cnt;
    logic        trig;
    logic [22:0] prog_cnt;
    logic [2:0]  stall_cnt;
    logic [7:0]  rdata;
  } nvbc_regs_t;
endpackage

// >>> rtl/nvbc_ctrl.sv
// io-register controller for a 128-byte byte-wide nonvolatile data store
`timescale 1ns/1ps
`include "nvbc_defines.svh"

// Contract
// - store holds 128 bytes addressed linearly by a 7-bit index
// - index register bit 7 reads zero; bits 6..0 are the index
// - value register supplies write data and receives read data
// - control bits 7 and 6 read as zero
// - action field: 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms
// - action field writes ignored while trigger is set
// - reset returns action field to 00 unless programming; a control write in the same cycle loads the written action instead
// - ready interrupt needs its enable and the global enable
// - ready interrupt is a level while the store is ready
// - arm bit self-clears four cycles after software sets it
// - trigger starts programming only within four cycles of arming
// - trigger stays set as busy until programming time elapses
// - cpu stalled two cycles after trigger set
// - read strobe loads value at once and stalls cpu four cycles
// - busy refuses read strobes and index changes
// - write-only to an unerased byte leaves undefined contents
// - reset does not abort programming in progress
module nvbc_ctrl (
  input  wire logic           mclk,       // cpu clock, 50 MHz
  input  wire logic           srst,       // synchronous reset, active high
  input  wire nvbc_pkg::nvbc_io_t io,     // io-space access from the cpu
  input  wire logic           osc_tick,   // one pulse per calibrated oscillator cycle
  input  wire logic           global_ie,  // global interrupt enable of the cpu flags
  output logic [7:0]          rdata,      // registered read data
  output logic                cpu_stall,  // holds the cpu before its next instruction
  output logic                ready_irq,  // level ready interrupt request
  output logic                busy        // programming in progress
);
  // ----------------------------------------------------------------
  // timing counts in oscillator ticks
  // ----------------------------------------------------------------
  localparam logic [22:0] ERWR_TICKS  =
    23'((`NVBC_ERWR_US * `NVBC_OSC_KHZ) / 1000);
  localparam logic [22:0] SPLIT_TICKS =
    23'((`NVBC_SPLIT_US * `NVBC_OSC_KHZ) / 1000);

  nvbc_pkg::nvbc_regs_t s_q;
  nvbc_pkg::nvbc_regs_t s_d;
  logic [7:0]           mem [0:127];
  logic [7:0]           mem_rd;
  logic                 mem_we;
  logic [7:0]           mem_wd;
  logic                 wr_ctl;
  logic                 done;

  assign mem_rd = mem[s_q.index];
  assign wr_ctl = io.wr && io.sel == `NVBC_SEL_CONTROL;
  assign done   = s_q.st == nvbc_pkg::NVBC_PROG && osc_tick && s_q.prog_cnt == 23'h1;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d    = s_q;
    mem_we = 1'b0;
    mem_wd = mem_rd;
    if (s_q.stall_cnt != 3'h0)
      s_d.stall_cnt = s_q.stall_cnt - 3'h1;
    if (s_q.arm)
    begin
      s_d.arm_cnt = s_q.arm_cnt - 3'h1;
      if (s_q.arm_cnt == 3'h1)
        s_d.arm = 1'b0;
    end
    case (s_q.st)
      nvbc_pkg::NVBC_IDLE:
      begin
        if (io.wr && io.sel == `NVBC_SEL_INDEX)
          s_d.index = io.wdata[6:0];
        if (io.wr && io.sel == `NVBC_SEL_VALUE)
          s_d.value = io.wdata;
        if (wr_ctl)
        begin
          s_d.act    = io.wdata[`NVBC_ACT_HI:`NVBC_ACT_LO];
          s_d.rdy_ie = io.wdata[`NVBC_RDY_IE];
          if (io.wdata[`NVBC_ARM])
          begin
            s_d.arm     = 1'b1;
            s_d.arm_cnt = `NVBC_ARM_CYCLES;
          end
          // trigger counts only while a live arm is pending
          if (io.wdata[`NVBC_TRIG] && s_q.arm
              && io.wdata[`NVBC_ACT_HI:`NVBC_ACT_LO] != 2'h3)
          begin
            s_d.trig      = 1'b1;
            s_d.arm       = 1'b0;
            s_d.st        = nvbc_pkg::NVBC_PROG;
            s_d.stall_cnt = `NVBC_PROG_STALL;
            s_d.prog_cnt  = (io.wdata[`NVBC_ACT_HI:`NVBC_ACT_LO] == `NVBC_ACT_ERWR)
                            ? ERWR_TICKS : SPLIT_TICKS;
          end
          else if (io.wdata[`NVBC_RSTB])
          begin
            s_d.value     = mem_rd;
            s_d.stall_cnt = `NVBC_READ_STALL;
          end
        end
        else if (srst)
          s_d.act = `NVBC_ACT_RESET;
      end
      nvbc_pkg::NVBC_PROG:
      begin
        // index, action and read strobe all frozen here
        if (io.wr && io.sel == `NVBC_SEL_VALUE)
          s_d.value = io.wdata;
        if (wr_ctl)
          s_d.rdy_ie = io.wdata[`NVBC_RDY_IE];
        if (osc_tick)
          s_d.prog_cnt = s_q.prog_cnt - 23'h1;
        if (done)
        begin
          s_d.trig = 1'b0;
          s_d.st   = nvbc_pkg::NVBC_IDLE;
          mem_we   = 1'b1;
          case (s_q.act)
            `NVBC_ACT_ERASE: mem_wd = `NVBC_ERASED_BYTE;
            // wired-and models the unerased write loss
            `NVBC_ACT_WRITE: mem_wd = mem_rd & s_q.value;
            default:         mem_wd = s_q.value;
          endcase
        end
      end
      default: s_d.st = nvbc_pkg::NVBC_IDLE;
    endcase
    // reset clears enable, arm, stall and read data, not index, value or an operation in flight
    if (srst)
    begin
      s_d.rdy_ie    = 1'b0;
      s_d.arm       = 1'b0;
      s_d.arm_cnt   = 3'h0;
      s_d.stall_cnt = 3'h0;
      s_d.rdata     = 8'h00;
    end
    else
    begin
      s_d.rdata = 8'h00;
      if (io.rd)
        case (io.sel)
          `NVBC_SEL_INDEX:   s_d.rdata = {1'b0, s_q.index};
          `NVBC_SEL_VALUE:   s_d.rdata = s_q.value;
          `NVBC_SEL_CONTROL: s_d.rdata = {2'b00, s_q.act, s_q.rdy_ie,
                                          s_q.arm, s_q.trig, 1'b0};
          default:           s_d.rdata = 8'h00;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // state register and storage array
  // ----------------------------------------------------------------
  // starts low so a reset at the very first clock edge clears every field; later resets
  // leave an operation in flight alone
  logic boot_q = 1'b0;
  always_ff @(posedge mclk)
  begin
    boot_q <= 1'b1;
    if (srst && !boot_q)
    begin
      s_q       <= '0;
      s_q.st    <= nvbc_pkg::NVBC_IDLE;
    end
    else
      s_q <= s_d;
    if (mem_we)
      mem[s_q.index] <= mem_wd;
  end

  assign rdata     = s_q.rdata;
  assign cpu_stall = s_q.stall_cnt != 3'h0;
  assign busy      = s_q.trig;
  assign ready_irq = s_q.rdy_ie && global_ie && !s_q.trig;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence arm_wr_s;
    wr_ctl && io.wdata[`NVBC_ARM] && !io.wdata[`NVBC_TRIG] && !srst
      && s_q.st == nvbc_pkg::NVBC_IDLE;
  endsequence

  arm_self_clear_a: assert property (@(posedge mclk) disable iff (srst)
    arm_wr_s ##1 !wr_ctl[*4] |=> !s_q.arm)
    else $error("arm bit did not clear after four cycles");
  trig_needs_arm_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(s_q.trig) |-> $past(s_q.arm))
    else $error("programming started without arm");
  prog_stall_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(s_q.trig) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("trigger stall not two cycles");
  index_frozen_a: assert property (@(posedge mclk) disable iff (srst)
    s_q.trig && $past(s_q.trig) |-> $stable(s_q.index))
    else $error("index changed while busy");
  act_frozen_a: assert property (@(posedge mclk)
    $past(s_q.trig) && s_q.trig |-> $stable(s_q.act))
    else $error("action field changed while busy");
  irq_level_a: assert property (@(posedge mclk) disable iff (srst)
    ready_irq == (s_q.rdy_ie && global_ie && !busy))
    else $error("ready interrupt mismatch");
  idx_top_zero_a: assert property (@(posedge mclk) disable iff (srst)
    $past(io.rd) && $past(io.sel) == `NVBC_SEL_INDEX |-> !rdata[7])
    else $error("index bit 7 not zero");
  ctl_res_zero_a: assert property (@(posedge mclk) disable iff (srst)
    $past(io.rd) && $past(io.sel) == `NVBC_SEL_CONTROL |-> rdata[7:6] == 2'b00)
    else $error("control reserved bits not zero");
  busy_clear_a: assert property (@(posedge mclk) disable iff (srst)
    done |=> !busy)
    else $error("busy did not clear on completion");

  // ----------------------------------------------------------------
  // access, programming and reset checks
  // ----------------------------------------------------------------
  // a strobe only counts when it does not also start programming
  sequence read_strobe_s;
    wr_ctl && io.wdata[`NVBC_RSTB] && !io.wdata[`NVBC_TRIG] && !srst
      && s_q.st == nvbc_pkg::NVBC_IDLE;
  endsequence

  sequence four_stall_s;
    cpu_stall[*4] ##1 !cpu_stall;
  endsequence

  read_stall_a: assert property (@(posedge mclk) disable iff (srst)
    read_strobe_s |=> four_stall_s)
    else $error("read strobe stall not four cycles");

  read_load_a: assert property (@(posedge mclk) disable iff (srst)
    read_strobe_s |=> s_q.value == $past(mem_rd))
    else $error("read strobe did not load the value register");

  value_write_a: assert property (@(posedge mclk) disable iff (srst)
    io.wr && io.sel == `NVBC_SEL_VALUE |=> s_q.value == $past(io.wdata))
    else $error("value register write lost");

  index_write_a: assert property (@(posedge mclk) disable iff (srst)
    io.wr && io.sel == `NVBC_SEL_INDEX && s_q.st == nvbc_pkg::NVBC_IDLE
      |=> s_q.index == $past(io.wdata[6:0]))
    else $error("index register write lost");

  busy_no_read_a: assert property (@(posedge mclk) disable iff (srst)
    s_q.st == nvbc_pkg::NVBC_PROG && wr_ctl |=> $stable(s_q.value))
    else $error("read strobe taken while busy");

  busy_no_arm_a: assert property (@(posedge mclk) disable iff (srst)
    s_q.st == nvbc_pkg::NVBC_PROG && wr_ctl |=> !s_q.arm)
    else $error("arm taken while busy");

  trig_late_a: assert property (@(posedge mclk) disable iff (srst)
    wr_ctl && io.wdata[`NVBC_TRIG] && !s_q.arm && !s_q.trig |=> !s_q.trig)
    else $error("trigger took effect without a live arm");

  act_reserved_a: assert property (@(posedge mclk) disable iff (srst)
    wr_ctl && io.wdata[`NVBC_ACT_HI:`NVBC_ACT_LO] == 2'h3 && !s_q.trig |=> !s_q.trig)
    else $error("reserved action started programming");

  erwr_ticks_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(s_q.trig) && s_q.act == `NVBC_ACT_ERWR |-> s_q.prog_cnt == ERWR_TICKS)
    else $error("erase and write time not loaded");

  split_ticks_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(s_q.trig) && s_q.act != `NVBC_ACT_ERWR |-> s_q.prog_cnt == SPLIT_TICKS)
    else $error("split operation time not loaded");

  prog_count_a: assert property (@(posedge mclk) disable iff (srst)
    s_q.st == nvbc_pkg::NVBC_PROG && osc_tick && !done
      |=> s_q.prog_cnt == $past(s_q.prog_cnt) - 23'h1)
    else $error("programming counter did not advance on a tick");

  erase_fill_a: assert property (@(posedge mclk) disable iff (srst)
    done && s_q.act == `NVBC_ACT_ERASE |-> mem_we && mem_wd == `NVBC_ERASED_BYTE)
    else $error("erase did not leave the erased byte");

  write_and_a: assert property (@(posedge mclk) disable iff (srst)
    done && s_q.act == `NVBC_ACT_WRITE |-> mem_we && (mem_wd & ~s_q.value) == 8'h00)
    else $error("write-only set bits that were not in the data");

  atomic_data_a: assert property (@(posedge mclk) disable iff (srst)
    done && s_q.act == `NVBC_ACT_ERWR |-> mem_we && mem_wd == s_q.value)
    else $error("erase and write stored the wrong byte");

  arm_count_a: assert property (@(posedge mclk) disable iff (srst)
    s_q.arm |-> s_q.arm_cnt != 3'h0)
    else $error("arm set with an expired window");

  irq_busy_a: assert property (@(posedge mclk) disable iff (srst)
    busy |-> !ready_irq)
    else $error("ready interrupt raised while busy");

  irq_gie_a: assert property (@(posedge mclk) disable iff (srst)
    !global_ie |-> !ready_irq)
    else $error("ready interrupt raised with global enable low");

  // the reset checks run through reset on purpose
  reset_act_a: assert property (@(posedge mclk)
    srst && !s_q.trig && !wr_ctl |=> s_q.act == `NVBC_ACT_RESET)
    else $error("reset did not clear the action field");

  reset_keep_a: assert property (@(posedge mclk)
    srst && s_q.trig && !done |=> s_q.trig)
    else $error("reset aborted programming");

  reset_clear_a: assert property (@(posedge mclk)
    srst |=> !s_q.arm && !cpu_stall)
    else $error("reset left arm or stall set");
endmodule

// >>> sim/nvbc_cpu_model.sv
// behavioural cpu side issuing io-space accesses to the controller
`timescale 1ns/1ps
module nvbc_cpu_model (
  input  wire logic         mclk, // cpu clock
  input  wire logic [7:0]   rdata, // read data from the controller
  output nvbc_pkg::nvbc_io_t io    // io-space access
);
  initial
  begin
    io = '0;
  end
  // launch after a falling edge, taken at the next rising edge;
  // released lines show the inverse so stale data is never mistaken
  task automatic access(input logic w, input logic [1:0] s, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge mclk);
    io = '{wr: w, rd: !w, sel: s, wdata: d};
    @(negedge mclk);
    io = '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: ~d};
    q = rdata;
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench of the nonvolatile store controller
`timescale 1ns/1ps
`include "nvbc_defines.svh"
`define CHK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", n, e, g); \
    end \
  end
module tb;
  localparam int ERWR  = `NVBC_ERWR_US * `NVBC_OSC_KHZ / 1000;
  localparam int SPLIT = `NVBC_SPLIT_US * `NVBC_OSC_KHZ / 1000;
  logic               mclk = 1'b0;
  logic               srst = 1'b1;
  logic               osc_tick = 1'b0;
  logic               global_ie = 1'b0;
  logic [7:0]         rdata;
  logic [7:0]         q;
  logic               cpu_stall;
  logic               ready_irq;
  logic               busy;
  nvbc_pkg::nvbc_io_t io;
  int                 fail_count = 0;
  int                 total_checks = 0;
  int                 n;
  always #10 mclk = ~mclk;
  nvbc_cpu_model cpu (.mclk(mclk), .rdata(rdata), .io(io));
  nvbc_ctrl uut (.mclk(mclk), .srst(srst), .io(io), .osc_tick(osc_tick),
                 .global_ie(global_ie), .rdata(rdata), .cpu_stall(cpu_stall),
                 .ready_irq(ready_irq), .busy(busy));
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    cpu.access(1'b1, s, d, q);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    cpu.access(1'b0, s, 8'h00, q);
    `CHK("rdata", e, q)
  endtask
  task automatic count_while(input logic which);
    n = 0;
    while ((which ? busy : cpu_stall) === 1'b1 && n < 40000)
    begin
      n++;
      @(negedge mclk);
    end
  endtask
  // index and data first, then arm and trigger two cycles apart
  task automatic prog(input logic [1:0] act, input logic [7:0] idx, input logic [7:0] v);
    count_while(1'b1);
    wr(2'h0, idx);
    wr(2'h1, v);
    wr(2'h2, {2'h0, act, 4'h4});
    wr(2'h2, {2'h0, act, 4'hA});
    `CHK("busy", 1'b1, busy)
    count_while(1'b0);
    `CHK("trig stall", 2, n)
  endtask
  task automatic read_back(input logic [7:0] idx, input logic [7:0] e);
    wr(2'h0, idx);
    wr(2'h1, ~e);
    wr(2'h2, 8'h01);
    count_while(1'b0);
    `CHK("read stall", 4, n)
    rd(2'h1, e);
  endtask
  task automatic t_regs;
    rd(2'h2, 8'h00);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'h7F);
    rd(2'h3, 8'h00);
  endtask
  task automatic t_arm;
    wr(2'h0, 8'h05);
    wr(2'h2, 8'h02);
    `CHK("busy no arm", 1'b0, busy)
    wr(2'h2, 8'h04);
    rd(2'h2, 8'h04);
    repeat (4) @(negedge mclk);
    rd(2'h2, 8'h00);
    wr(2'h2, 8'h02);
    `CHK("busy late", 1'b0, busy)
  endtask
  task automatic t_atomic;
    global_ie = 1'b1;
    prog(2'h0, 8'h05, 8'h3C);
    `CHK("irq busy", 1'b0, ready_irq)
    wr(2'h0, 8'h09);
    wr(2'h2, 8'h3B);
    rd(2'h2, 8'h0A);
    rd(2'h1, 8'h3C);
    rd(2'h0, 8'h05);
    count_while(1'b1);
    `CHK("erwr time", 1'b1, n > ERWR - 16 && n <= ERWR)
    `CHK("irq ready", 1'b1, ready_irq)
    global_ie = 1'b0;
    @(negedge mclk);
    `CHK("irq gie", 1'b0, ready_irq)
    global_ie = 1'b1;
    read_back(8'h05, 8'h3C);
  endtask
  task automatic t_split;
    prog(2'h1, 8'h05, 8'h00);
    repeat (100) @(negedge mclk);
    srst = 1'b1;
    @(negedge mclk);
    srst = 1'b0;
    rd(2'h2, 8'h12);
    count_while(1'b1);
    `CHK("reset kept busy", 1'b1, n > 1000)
    read_back(8'h05, 8'hFF);
    prog(2'h2, 8'h05, 8'h0F);
    count_while(1'b1);
    `CHK("split time", 1'b1, n > SPLIT - 16 && n <= SPLIT)
    read_back(8'h05, 8'h0F);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #(20 * 90000);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    osc_tick = 1'b1;
    t_regs();
    t_arm();
    t_atomic();
    t_split();
    report_and_stop();
  end
endmodule
